/* File: design/irbe_pkg.sv */
// Package for the infrared bi-phase frame encoder: register map, fields, timing.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone slave port.
package irbe_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned HALF_BIT_NS = 889;
    localparam int unsigned HALF_BIT_CYC = (HALF_BIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FRAME = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam int CTRL_SEND_BIT = 0;
    localparam int CTRL_LONG_BIT = 1;
    localparam int CTRL_IDLE_LVL_BIT = 2;
    localparam int FRAME_CMD_POS = 0;
    localparam int FRAME_ADDR_POS = 8;
    localparam int FRAME_TOG_POS = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam logic [31:0] RESET_FRAME = 32'h0000_0000;
    localparam int SHORT_BITS = 14;
    localparam int LONG_HDR_BITS = 20;
    localparam int LONG_WORD_BITS = 16;
    localparam int LONG_BITS = LONG_HDR_BITS + LONG_WORD_BITS;
    localparam logic [7:0] SHORT_TOG_SET = 8'h20;
    localparam logic [5:0] LONG_HDR_LEAD = 6'h3F;
    localparam logic [13:0] LONG_HDR_MID = 14'h0001;

    typedef struct packed {
        logic long_fmt;
        logic [7:0] toggle;
        logic [7:0] address;
        logic [7:0] command;
    } irbe_req_type;

    typedef struct packed {
        logic [5:0] nbits;
        logic [35:0] bits;
    } irbe_frame_type;
endpackage : irbe_pkg

/* File: design/irbe_skid.sv */
// Two-entry buffer between the register port and the frame encoder.
// Assumes one clock; both sides use valid and ready.
`timescale 1ns/1ps
module irbe_skid
    import irbe_pkg::*;
#(
    parameter int WIDTH = 25
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic rd_q, rd_d, wr_q, wr_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready_out = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out = mem_q[rd_q];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        mem_d = mem_q;
        if (push) begin
            mem_d[wr_q] = in_data_in;
        end
        wr_d = push ? ~wr_q : wr_q;
        rd_d = pop ? ~rd_q : rd_q;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : irbe_skid

/* File: design/irbe_encoder.sv */
// Infrared remote frame encoder, short 14-bit and long 36-bit bi-phase frames.
// Assumes a classic Wishbone master and an LED driver on the compare output.
//
// Summary of operation
// - Short frame is exactly fourteen bi-phase coded bits.
// - Short frame opens with two start bits, both one.
// - Third short-frame bit is the requested toggle.
// - Short frame carries a five-bit system address after toggle.
// - Short frame carries a six-bit command after address.
// - Every bit is Manchester coded; mid-bit edge direction gives value.
// - Timing from the timer; waveform on timer compare A output.
// - No interrupts; output logic alone shapes the waveform.
// - Long frame payload word is sixteen bits.
// - Long frame header is twenty bits including toggle.
// - Long frame carries an eight-bit system address.
// - Long frame carries an eight-bit command.
`timescale 1ns/1ps
module irbe_encoder
    import irbe_pkg::*;
#(
    parameter int HALF_CYC = HALF_BIT_CYC
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Infrared output
    output logic timer_compare_a_output_out,
    output logic busy_out
);
    typedef enum {ST_IDLE, ST_FIRST, ST_SECOND} irbe_state_type;

    function automatic irbe_frame_type build_frame(input irbe_req_type r);
        irbe_frame_type f;
        f = '0;
        if (!r.long_fmt) begin
            f.nbits = 6'(SHORT_BITS);
            // Start bits, toggle, address, command, MSB first
            f.bits[35:22] = {2'b11, (r.toggle == SHORT_TOG_SET), r.address[4:0],
                r.command[5:0]};
        end else begin
            f.nbits = 6'(LONG_BITS);
            // Header with toggle, then address and command words
            f.bits = {LONG_HDR_LEAD, LONG_HDR_MID[13:1], r.toggle[0],
                r.address, r.command};
        end
        return f;
    endfunction : build_frame

    logic ack_q, ack_d;
    logic long_q, long_d;
    logic idle_lvl_q, idle_lvl_d;
    logic [31:0] frame_q, frame_d;
    logic [31:0] rdata_q, rdata_d;
    logic push;
    logic buf_ready, buf_valid, take;
    irbe_req_type req_in, req_out;
    irbe_state_type st_q, st_d;
    logic [35:0] sh_q, sh_d;
    logic [5:0] left_q, left_d;
    logic [31:0] tim_q, tim_d;
    logic pin_q, pin_d;
    logic bus_req;
    logic wr_go;
    logic tim_done;
    irbe_frame_type nf;

    assign bus_req = wb_cyc_in && wb_stb_in && !ack_q;
    // Writes land on the edge at which the master samples ack
    assign wr_go = wb_cyc_in && wb_stb_in && wb_we_in && ack_q;
    assign push = wr_go && (wb_adr_in == OFS_CTRL) && wb_sel_in[0]
        && wb_dat_in[CTRL_SEND_BIT];
    assign req_in = '{long_fmt: wb_dat_in[CTRL_LONG_BIT], toggle: frame_q[FRAME_TOG_POS +: 8],
        address: frame_q[FRAME_ADDR_POS +: 8], command: frame_q[FRAME_CMD_POS +: 8]};

    // Register port
    always_comb begin
        ack_d = bus_req;
        long_d = long_q;
        idle_lvl_d = idle_lvl_q;
        frame_d = frame_q;
        rdata_d = 32'h0000_0000;
        if (wr_go) begin
            if (wb_adr_in == OFS_CTRL && wb_sel_in[0]) begin
                long_d = wb_dat_in[CTRL_LONG_BIT];
                idle_lvl_d = wb_dat_in[CTRL_IDLE_LVL_BIT];
            end
            if (wb_adr_in == OFS_FRAME) begin
                for (int i = 0; i < 4; i++) begin
                    if (wb_sel_in[i]) begin
                        frame_d[i*8 +: 8] = wb_dat_in[i*8 +: 8];
                    end
                end
            end
        end
        if (bus_req && !wb_we_in) begin
            unique case (wb_adr_in)
                OFS_CTRL: rdata_d = {29'h0, idle_lvl_q, long_q, 1'b0};
                OFS_FRAME: rdata_d = frame_q;
                OFS_STATUS: rdata_d = {30'h0, !buf_ready, st_q != ST_IDLE || buf_valid};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_q <= 1'b0;
            long_q <= 1'b0;
            idle_lvl_q <= 1'b0;
            frame_q <= RESET_FRAME;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            long_q <= long_d;
            idle_lvl_q <= idle_lvl_d;
            frame_q <= frame_d;
            rdata_q <= rdata_d;
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdata_q;

    irbe_skid #(.WIDTH($bits(irbe_req_type))) u_buf (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .in_valid_in(push),
        .in_data_in(req_in),
        .in_ready_out(buf_ready),
        .out_valid_out(buf_valid),
        .out_data_out(req_out),
        .out_ready_in(take)
    );

    // Only accepted while idle
    assign take = buf_valid && (st_q == ST_IDLE);
    assign nf = build_frame(req_out);
    assign tim_done = (tim_q == 32'(HALF_CYC - 1));

    // Frame sequencer, no interrupt involved
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        left_d = left_q;
        tim_d = tim_done ? 32'h0 : tim_q + 32'h1;
        pin_d = pin_q;
        unique case (st_q)
            ST_IDLE: begin
                tim_d = 32'h0;
                pin_d = idle_lvl_q;
                if (take) begin
                    sh_d = nf.bits;
                    left_d = nf.nbits;
                    st_d = ST_FIRST;
                    pin_d = ~nf.bits[35];
                end
            end
            ST_FIRST: begin
                if (tim_done) begin
                    pin_d = sh_q[35];
                    st_d = ST_SECOND;
                end
            end
            ST_SECOND: begin
                if (tim_done) begin
                    sh_d = {sh_q[34:0], 1'b0};
                    left_d = left_q - 6'h1;
                    if (left_q == 6'h1) begin
                        st_d = ST_IDLE;
                        pin_d = idle_lvl_q;
                    end else begin
                        st_d = ST_FIRST;
                        pin_d = ~sh_q[34];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= ST_IDLE;
            sh_q <= '0;
            left_q <= 6'h0;
            tim_q <= 32'h0;
            pin_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            left_q <= left_d;
            tim_q <= tim_d;
            pin_q <= pin_d;
        end
    end

    assign timer_compare_a_output_out = pin_q;
    assign busy_out = (st_q != ST_IDLE);

    // Checks
    logic bit_val;
    assign bit_val = sh_q[35];

    property p_mid_edge;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (st_q == ST_FIRST && tim_done) |=> (pin_q == bit_val);
    endproperty
    a_mid_edge: assert property (p_mid_edge) else $error("mid-bit level wrong");

    property p_first_half;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (st_q == ST_FIRST) |-> (pin_q == !bit_val);
    endproperty
    a_first_half: assert property (p_first_half) else $error("first half wrong");

    property p_start;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (take && !req_out.long_fmt) |=> (sh_q[35:34] == 2'b11 && left_q == 6'h0E);
    endproperty
    a_start: assert property (p_start) else $error("short frame header wrong");

    property p_toggle;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (take && !req_out.long_fmt) |=>
            (sh_q[33] == ($past(req_out.toggle) == SHORT_TOG_SET));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle bit wrong");

    property p_long_len;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (take && req_out.long_fmt) |=> (left_q == 6'h24 && sh_q[7:0] == $past(req_out.command));
    endproperty
    a_long_len: assert property (p_long_len) else $error("long frame wrong");

    property p_idle_pin;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (st_q == ST_IDLE && !$past(take)) |-> (pin_q == $past(idle_lvl_q));
    endproperty
    a_idle_pin: assert property (p_idle_pin) else $error("idle level wrong");

    property p_busy;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        take |=> busy_out;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not raised");

    property p_no_take_busy;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (busy_out && buf_valid) |=> buf_valid;
    endproperty
    a_no_take_busy: assert property (p_no_take_busy) else $error("taken while busy");

    property p_addr;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (take && !req_out.long_fmt) |=> (sh_q[32:28] == $past(req_out.address[4:0]));
    endproperty
    a_addr: assert property (p_addr) else $error("address field wrong");

    property p_cmd;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (take && !req_out.long_fmt) |=> (sh_q[27:22] == $past(req_out.command[5:0]));
    endproperty
    a_cmd: assert property (p_cmd) else $error("command field wrong");

    property p_long_hdr;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (take && req_out.long_fmt) |=>
            (sh_q[35:16] == {LONG_HDR_LEAD, LONG_HDR_MID[13:1], $past(req_out.toggle[0])});
    endproperty
    a_long_hdr: assert property (p_long_hdr) else $error("long header wrong");

    property p_long_addr;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (take && req_out.long_fmt) |=> (sh_q[15:8] == $past(req_out.address));
    endproperty
    a_long_addr: assert property (p_long_addr) else $error("long address wrong");

    property p_last_half;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (st_q == ST_SECOND && tim_done && left_q == 6'h01) |=>
            (!busy_out && pin_q == $past(idle_lvl_q));
    endproperty
    a_last_half: assert property (p_last_half) else $error("frame end wrong");

    property p_half_hold;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (busy_out && !tim_done) |=> $stable(pin_q);
    endproperty
    a_half_hold: assert property (p_half_hold) else $error("pin moved mid half");

    c_short: cover property (@(posedge ref_clk_in) take && !req_out.long_fmt);
    c_long: cover property (@(posedge ref_clk_in) take && req_out.long_fmt);
    c_full: cover property (@(posedge ref_clk_in) !buf_ready);
    c_back: cover property (@(posedge ref_clk_in) busy_out ##1 !busy_out ##1 busy_out);
    c_idle_high: cover property (@(posedge ref_clk_in) !busy_out && pin_q);
endmodule : irbe_encoder

/* File: verification/irbe_ir_rx.sv */
// Infrared receiver model: decodes bi-phase frames from the compare pin.
// Assumes busy frames each burst and each half lasts HALF clock cycles.
`timescale 1ns/1ps
module irbe_ir_rx
    import irbe_pkg::*;
#(
    parameter int HALF = 8
) (
    // Clock and line
    input wire logic ref_clk_in,
    input wire logic pin_in,
    input wire logic busy_in,
    // Decoded frame
    output logic [35:0] bits_out,
    output int nbits_out,
    output logic bad_out,
    output int cnt_out
);
    logic a;
    logic gone;

    task automatic wt(input int n);
        repeat (n) begin
            @(posedge ref_clk_in);
            if (!busy_in) gone = 1'b1;
        end
    endtask : wt

    initial begin
        cnt_out = 0;
        forever begin
            @(posedge ref_clk_in iff busy_in);
            gone = 1'b0;
            bits_out = '0;
            nbits_out = 0;
            bad_out = 1'b0;
            forever begin
                wt(HALF / 2);
                a = pin_in;
                wt(HALF);
                bad_out = bad_out | (a === pin_in);
                bits_out = {bits_out[34:0], pin_in};
                nbits_out++;
                wt(HALF - HALF / 2);
                if (gone) break;
            end
            cnt_out++;
        end
    end
endmodule : irbe_ir_rx

/* File: verification/testbench.sv */
// Self-checking bench: queues frames over Wishbone, decodes the pin.
// Assumes the receiver model watches busy and the compare output.
`timescale 1ns/1ps
module testbench
    import irbe_pkg::*;
;
    localparam int HC = 8;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic pin;
    logic busy;
    logic [35:0] rbits;
    int rn;
    logic rbad;
    int rcnt;
    int fails = 0;
    int n_tests = 0;
    logic [35:0] qb[$];
    int qn[$];
    logic [31:0] seed = 32'hAD93;
    logic [31:0] q;
    logic [7:0] t;
    logic lg;
    logic idle = 1'b0;

    always #4 ref_clk_in = ~ref_clk_in;

    irbe_encoder #(.HALF_CYC(HC)) dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .timer_compare_a_output_out(pin), .busy_out(busy));
    irbe_ir_rx #(.HALF(HC)) rx (.ref_clk_in(ref_clk_in), .pin_in(pin), .busy_in(busy),
        .bits_out(rbits), .nbits_out(rn), .bad_out(rbad), .cnt_out(rcnt));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic finish_test();
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [35:0] s, input logic [35:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask : chk

    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        i = 0;
        do begin
            @(posedge ref_clk_in);
            i++;
        end while (ack !== 1'b1 && i < 64);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t bus timeout", $time);
            finish_test();
        end
        @(posedge ref_clk_in);
    endtask : wbx

    task automatic send(input logic lg, input logic [7:0] tg, input logic [7:0] a,
            input logic [7:0] c, input logic push);
        wbx(1'b1, OFS_FRAME, {8'h00, tg, a, c}, q);
        wbx(1'b1, OFS_CTRL, {29'h0, idle, lg, 1'b1}, q);
        if (push) begin
            qb.push_back(lg ? {6'h3F, 13'h0, tg[0], a, c}
                : {22'h0, 2'h3, tg == 8'h20, a[4:0], c[5:0]});
            qn.push_back(lg ? 36 : 14);
        end
    endtask : send

    task automatic drain();
        int i;
        i = 0;
        while ((qn.size() > 0 || busy !== 1'b0) && i < 3000) begin
            @(posedge ref_clk_in);
            i++;
        end
        if (qn.size() > 0 || busy !== 1'b0) begin
            fails++;
            $display("[FAIL] %0t drain timeout", $time);
            finish_test();
        end
        chk(pin, idle);
    endtask : drain

    always @(rcnt) begin
        if (rcnt > 0 && qn.size() == 0) begin
            fails++;
            $display("[FAIL] %0t unexpected frame", $time);
        end else if (rcnt > 0) begin
            chk(rbits, qb.pop_front());
            chk(36'(rn), 36'(qn.pop_front()));
            chk(rbad, 1'b0);
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        @(posedge ref_clk_in);
        wbx(1'b0, OFS_STATUS, 32'h0, q);
        chk(q, 32'h0);
        wbx(1'b0, OFS_FRAME, 32'h0, q);
        chk(q, RESET_FRAME);
        wbx(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
        wbx(1'b0, 8'h0C, 32'h0, q);
        chk(q, 32'h0);
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            idle = seed[2];
            lg = (k == 3) ? 1'b0 : ((k == 4) ? 1'b1 : seed[0]);
            t = lg ? {7'h00, k[0]} : {2'h0, k[0], 5'h00};
            send(lg, t, k < 2 ? 8'(5 * k) : seed[15:8], seed[23:16], 1'b1);
            wbx(1'b0, OFS_CTRL, 32'h0, q);
            chk(q, {29'h0, idle, lg, 1'b0});
            wbx(1'b0, OFS_STATUS, 32'h0, q);
            chk(q[0], 1'b1);
            drain();
        end
        idle = 1'b0;
        repeat (3) send(1'b0, 8'h20, 8'h05, 8'h0C, 1'b1);
        wbx(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[1], 1'b1);
        send(1'b0, 8'h00, 8'h00, 8'h01, 1'b0);
        drain();
        wbx(1'b0, OFS_STATUS, 32'h0, q);
        chk(q, 32'h0);
        finish_test();
    end
endmodule : testbench
